// ==== iam_pkg.sv ====
// Constants and types shared by the indirect address mapper and its return stack.
//
// Overview of operation
// - With stack fault reset enabled, a push onto a full sixteen-level stack resets the device and sets the overflow flag.
// - With stack fault reset enabled, a pop from an empty stack resets the device and sets the underflow flag.
// - A return loads the top-of-stack address into the program counter and then pops the stack by one level.
// - An access to the indirect data port really reaches the register addressed by the pointer; the port stores nothing.
// - A pointer that addresses an indirect data port itself reads as zero and discards writes.
// - The pointer is the high byte above the low byte, a 16-bit address into 65536 locations.
// - Pointer values 0x000 to 0xfff map straight onto absolute data memory addresses.
// - Pointer values 0x2000 to 0x29af form a linear view of the 80-byte general purpose blocks of banks 0 to 30.
// - Indirect reads of unimplemented locations return 0x00.
// - Stepping the linear pointer past one bank's last general purpose byte reaches the next bank's first one.
// - The 16 common bytes shared by all banks are not part of the linear view.
// - With the top pointer bit set, the lower 15 bits address a program flash word.
// - Indirect flash reads return only the low 8 bits of the word.
// - Indirect writes to the flash region never modify program memory.
// - An indirect flash read takes one extra instruction cycle.
package iam_pkg;

	// ---------------------------------------------------------------
	// Return stack
	// ---------------------------------------------------------------
	localparam int          STACK_DEPTH = 16;
	localparam int          STACK_IDX_W = 4;
	localparam int          STACK_PTR_W = 5;
	localparam int          PC_W        = 15;
	localparam logic [4:0]  STACK_EMPTY = 5'h1f;
	localparam logic [4:0]  STACK_FULL  = 5'h0f;

	// ---------------------------------------------------------------
	// Indirect address space
	// ---------------------------------------------------------------
	localparam int          PTR_W        = 16;
	localparam int          DATA_ADDR_W  = 12;
	localparam int          FLASH_W      = 14;
	localparam int          FLASH_SEL    = 15;
	localparam logic [15:0] TRAD_LAST    = 16'h0fff;
	localparam logic [15:0] LIN_FIRST    = 16'h2000;
	localparam logic [15:0] LIN_LAST     = 16'h29af;
	localparam logic [11:0] LIN_BLOCK    = 12'h050;
	localparam logic [6:0]  RAM_BASE     = 7'h20;
	localparam logic [5:0]  PORT_ROW     = 6'h00;
	localparam logic [7:0]  READ_ZERO    = 8'h00;

	// ---------------------------------------------------------------
	// Indirect access sequencer
	// ---------------------------------------------------------------
	typedef enum logic [4:0]
	{
		IAM_IDLE    = 5'b00001,
		IAM_ISSUE   = 5'b00010,
		IAM_EXTRA   = 5'b00100,
		IAM_CAPTURE = 5'b01000,
		IAM_DONE    = 5'b10000
	} iam_access_state_type;

endpackage

// ==== iam_stack_if.sv ====
// Connection between the stack controller and the return stack storage.
`timescale 1ns/10ps
interface iam_stack_if;
	import iam_pkg::*;

	logic                   writeEnable;
	logic [STACK_IDX_W-1:0] writeIndex;
	logic [PC_W-1:0]        writeData;
	logic [STACK_IDX_W-1:0] readIndex;
	logic [PC_W-1:0]        readData;

	modport ctrl (output writeEnable, output writeIndex, output writeData, output readIndex, input readData);
	modport mem  (input writeEnable, input writeIndex, input writeData, input readIndex, output readData);
endinterface

// ==== iam_return_stack.sv ====
// Sixteen-level return address storage with a registered read port.
`timescale 1ns/10ps
module iam_return_stack
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Storage port
	iam_stack_if.mem stack
);
	import iam_pkg::*;

	logic [PC_W-1:0] levels [STACK_DEPTH];

	always_ff @(posedge clock)
	begin
		if (stack.writeEnable)
			levels[stack.writeIndex] <= stack.writeData;
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			stack.readData <= '0;
		else
			stack.readData <= levels[stack.readIndex];
	end
endmodule

// ==== iam_indirect_address_mapper.sv ====
// Indirect data access and return stack control with overflow and underflow reset.
`timescale 1ns/10ps
module iam_indirect_address_mapper
(
	// Clock and reset
	input  wire logic                             clock,
	input  wire logic                             rstn,
	// Return stack control from the core
	input  wire logic                             pushReq,
	input  wire logic [iam_pkg::PC_W-1:0]         pushAddr,
	input  wire logic                             popReq,
	input  wire logic                             stackFaultResetEnable,
	input  wire logic                             clearOverflowFlag,
	input  wire logic                             clearUnderflowFlag,
	// Return stack results
	output logic                                  pcLoad,
	output logic [iam_pkg::PC_W-1:0]              pcLoadValue,
	output logic [iam_pkg::STACK_PTR_W-1:0]       stackPtr,
	output logic                                  stackFaultReset,
	output logic                                  stackOverflowFlag,
	output logic                                  stackUnderflowFlag,
	// Indirect access from the core
	input  wire logic                             accReq,
	input  wire logic                             accWrite,
	input  wire logic [7:0]                       accWdata,
	input  wire logic [7:0]                       pointerHighByte,
	input  wire logic [7:0]                       pointerLowByte,
	output logic                                  accBusy,
	output logic                                  accDone,
	output logic [7:0]                            accRdata,
	// Data memory port
	output logic [iam_pkg::DATA_ADDR_W-1:0]       dataAddr,
	output logic                                  dataRe,
	output logic                                  dataWe,
	output logic [7:0]                            dataWdata,
	input  wire logic [7:0]                       dataRdata,
	// Program flash read port
	output logic [iam_pkg::PC_W-1:0]              flashAddr,
	output logic                                  flashRe,
	input  wire logic [iam_pkg::FLASH_W-1:0]      flashRdata
);
	import iam_pkg::*;

	// ---------------------------------------------------------------
	// Return stack
	// ---------------------------------------------------------------
	iam_stack_if stackBus ();

	iam_return_stack u_stack
	(
		.clock (clock),
		.rstn  (rstn),
		.stack (stackBus.mem)
	);

	logic popPending;
	logic stackFull;
	logic stackEmpty;
	logic popTake;
	logic pushTake;
	logic overflowEvent;
	logic underflowEvent;
	logic faultEvent;
	logic [STACK_PTR_W-1:0] next_stackPtr;

	assign stackFull      = stackPtr == STACK_FULL;
	assign stackEmpty     = stackPtr == STACK_EMPTY;
	assign popTake        = popReq && !popPending;
	// A pop and a push in the same cycle cannot both be right; the pop wins.
	assign pushTake       = pushReq && !popReq && !popPending;
	assign overflowEvent  = pushTake && stackFull && stackFaultResetEnable;
	assign underflowEvent = popTake && stackEmpty && stackFaultResetEnable;
	assign faultEvent     = overflowEvent || underflowEvent;

	assign stackBus.writeEnable = pushTake && !overflowEvent;
	assign stackBus.writeIndex  = stackPtr[STACK_IDX_W-1:0] + 4'h1;
	assign stackBus.writeData   = pushAddr;
	assign stackBus.readIndex   = stackPtr[STACK_IDX_W-1:0];

	// The top word is read on the pop request and loaded one cycle later.
	assign pcLoad      = popPending;
	assign pcLoadValue = stackBus.readData;

	// Without the fault reset a full stack wraps to level zero and an empty one stays empty.
	assign next_stackPtr = faultEvent ? STACK_EMPTY :
		pushTake ? {1'b0, stackBus.writeIndex} :
		(popPending && !stackEmpty) ? stackPtr - 5'h01 : stackPtr;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			stackPtr        <= STACK_EMPTY;
			popPending      <= 1'b0;
			stackFaultReset <= 1'b0;
		end
		else
		begin
			stackPtr        <= next_stackPtr;
			popPending      <= popTake && !underflowEvent;
			stackFaultReset <= faultEvent;
		end
	end

	// The flags survive the reset they cause; only the power-on reset or software clears them.
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			stackOverflowFlag  <= 1'b0;
			stackUnderflowFlag <= 1'b0;
		end
		else
		begin
			stackOverflowFlag  <= overflowEvent || (stackOverflowFlag && !clearOverflowFlag);
			stackUnderflowFlag <= underflowEvent || (stackUnderflowFlag && !clearUnderflowFlag);
		end
	end

	// ---------------------------------------------------------------
	// Pointer decode
	// ---------------------------------------------------------------
	logic [PTR_W-1:0] pointer;
	logic             inFlash;
	logic             inTrad;
	logic             inLinear;
	logic             isPortSelf;
	logic [11:0]      linOffset;
	logic [11:0]      linBankWide;
	logic [11:0]      linByteWide;
	logic [DATA_ADDR_W-1:0] linAddr;
	logic [DATA_ADDR_W-1:0] decodedAddr;
	logic             toData;

	assign pointer     = {pointerHighByte, pointerLowByte};
	assign inFlash     = pointer[FLASH_SEL];
	assign inTrad      = pointer <= TRAD_LAST;
	assign inLinear    = pointer >= LIN_FIRST && pointer <= LIN_LAST;
	assign isPortSelf  = inTrad && pointer[6:1] == PORT_ROW;
	// Within the linear region the offset from its base is simply the low twelve bits.
	assign linOffset   = pointer[11:0];
	assign linBankWide = linOffset / LIN_BLOCK;
	assign linByteWide = linOffset % LIN_BLOCK;
	// Consecutive offsets run off the end of one block into the next bank's first byte.
	assign linAddr     = {linBankWide[4:0], RAM_BASE + linByteWide[6:0]};
	assign decodedAddr = inLinear ? linAddr : pointer[DATA_ADDR_W-1:0];
	// Anything else outside the flash region, the port registers included, goes nowhere and reads as zero.
	assign toData      = (inTrad && !isPortSelf) || inLinear;

	// ---------------------------------------------------------------
	// Access sequencer
	// ---------------------------------------------------------------
	iam_access_state_type state;
	iam_access_state_type next_state;
	logic accTake;
	logic reqFlash;
	logic reqData;
	logic reqWrite;
	logic [7:0] next_accRdata;

	assign accTake = accReq && state == IAM_IDLE;
	assign accBusy = state != IAM_IDLE;
	assign accDone = state == IAM_DONE;
	assign dataRe  = state == IAM_ISSUE && reqData && !reqWrite;
	assign dataWe  = state == IAM_ISSUE && reqData && reqWrite;
	// The flash port has no write path at all, so a write there simply completes.
	assign flashRe = state == IAM_EXTRA;
	assign next_accRdata = reqWrite ? READ_ZERO :
		reqFlash ? flashRdata[7:0] :
		reqData ? dataRdata : READ_ZERO;

	always_comb
	begin
		next_state = state;
		unique case (state)
			IAM_IDLE:    if (accReq) next_state = IAM_ISSUE;
			IAM_ISSUE:   next_state = (reqFlash && !reqWrite) ? IAM_EXTRA : IAM_CAPTURE;
			IAM_EXTRA:   next_state = IAM_CAPTURE;
			IAM_CAPTURE: next_state = IAM_DONE;
			IAM_DONE:    next_state = IAM_IDLE;
			default:     next_state = IAM_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			state     <= IAM_IDLE;
			reqFlash  <= 1'b0;
			reqData   <= 1'b0;
			reqWrite  <= 1'b0;
			dataAddr  <= '0;
			dataWdata <= '0;
			flashAddr <= '0;
			accRdata  <= '0;
		end
		else
		begin
			state <= next_state;
			if (accTake)
			begin
				reqFlash  <= inFlash;
				reqData   <= toData;
				reqWrite  <= accWrite;
				dataAddr  <= decodedAddr;
				dataWdata <= accWdata;
				flashAddr <= pointer[PC_W-1:0];
			end
			if (state == IAM_CAPTURE)
				accRdata <= next_accRdata;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_overflow_reset;
		@(posedge clock) disable iff (!rstn)
		pushTake && stackFull && stackFaultResetEnable |=> stackFaultReset && stackOverflowFlag && stackPtr == 5'h1f;
	endproperty
	a_overflow_reset: assert property (p_overflow_reset) else $error("overflow did not reset the stack");

	property p_underflow_reset;
		@(posedge clock) disable iff (!rstn)
		popTake && stackEmpty && stackFaultResetEnable |=> stackFaultReset && stackUnderflowFlag && !pcLoad;
	endproperty
	a_underflow_reset: assert property (p_underflow_reset) else $error("underflow did not reset the stack");

	property p_return_pop;
		@(posedge clock) disable iff (!rstn)
		popTake && !stackEmpty |=> pcLoad ##1 stackPtr == $past(stackPtr, 2) - 5'h01;
	endproperty
	a_return_pop: assert property (p_return_pop) else $error("return did not load and pop");

	property p_port_reads_zero;
		@(posedge clock) disable iff (!rstn)
		accTake && isPortSelf |-> ##1 !dataWe && !dataRe ##2 accDone && accRdata == 8'h00;
	endproperty
	a_port_reads_zero: assert property (p_port_reads_zero) else $error("port self access not zero");

	property p_traditional_map;
		@(posedge clock) disable iff (!rstn)
		accTake && inTrad && !isPortSelf |=> (dataRe || dataWe) && dataAddr == $past(pointer[11:0]);
	endproperty
	a_traditional_map: assert property (p_traditional_map) else $error("traditional address wrong");

	property p_linear_ram;
		@(posedge clock) disable iff (!rstn)
		accTake && inLinear |=> dataAddr[6:0] >= 7'h20 && dataAddr[6:0] <= 7'h6f && dataAddr[11:7] <= 5'h1e;
	endproperty
	a_linear_ram: assert property (p_linear_ram) else $error("linear address outside a block");

	property p_flash_read;
		@(posedge clock) disable iff (!rstn)
		accTake && inFlash && !accWrite |-> !accDone [*4] ##1 accDone && accRdata == $past(flashRdata[7:0]);
	endproperty
	a_flash_read: assert property (p_flash_read) else $error("flash read wrong or late");

	property p_flash_no_write;
		@(posedge clock) disable iff (!rstn)
		accTake && inFlash && accWrite |=> (!dataWe && !flashRe) [*3];
	endproperty
	a_flash_no_write: assert property (p_flash_no_write) else $error("flash write reached memory");

	property p_unimplemented;
		@(posedge clock) disable iff (!rstn)
		accTake && !inFlash && !inTrad && !inLinear |-> ##1 !dataWe ##2 accDone && accRdata == 8'h00;
	endproperty
	a_unimplemented: assert property (p_unimplemented) else $error("unimplemented access not zero");
endmodule

// ==== iam_memory_model.sv ====
// Behavioural data memory and program flash on the far side of the indirect access port.
`timescale 1ns/10ps
module iam_memory_model
(
	// Clock
	input  wire logic                             clock,
	// Data memory port
	input  wire logic [iam_pkg::DATA_ADDR_W-1:0]  dataAddr,
	input  wire logic                             dataRe,
	input  wire logic                             dataWe,
	input  wire logic [7:0]                       dataWdata,
	output logic [7:0]                            dataRdata,
	// Program flash read port
	input  wire logic [iam_pkg::PC_W-1:0]         flashAddr,
	input  wire logic                             flashRe,
	output logic [iam_pkg::FLASH_W-1:0]           flashRdata
);
	import iam_pkg::*;

	logic [7:0] mem [0:4095];

	// -----------------------------------------------------------
	// Storage
	// -----------------------------------------------------------
	// Every location whose low byte is not 0xa5 starts nonzero so a stray pass-through there never reads as zero.
	initial
	begin
		for (int i = 0; i < 4096; i++)
			mem[i] = 8'(i) ^ 8'ha5;
	end

	// Read data is valid for one cycle only; afterwards it toggles so a late capture is caught.
	always @(posedge clock)
	begin
		if (dataWe)
			mem[dataAddr] <= dataWdata;
		dataRdata <= dataRe ? mem[dataAddr] : ~dataRdata;
		flashRdata <= flashRe ? (flashAddr[13:0] ^ 14'h2c3a) : ~flashRdata;
	end
endmodule

// ==== iam_indirect_address_mapper_tb_top.sv ====
// Self-checking testbench for the indirect address mapper and its return stack.
`timescale 1ns/10ps
module iam_indirect_address_mapper_tb_top;
	import iam_pkg::*;

	logic        clock = 1'b0;
	logic        rstn = 1'b0;
	logic        pushReq = 1'b0;
	logic [14:0] pushAddr = 15'h0000;
	logic        popReq = 1'b0;
	logic        stackFaultResetEnable = 1'b1;
	logic        clearOverflowFlag = 1'b0;
	logic        clearUnderflowFlag = 1'b0;
	logic        accReq = 1'b0;
	logic        accWrite = 1'b0;
	logic [7:0]  accWdata = 8'h00;
	logic [7:0]  pointerHighByte = 8'h00;
	logic [7:0]  pointerLowByte = 8'h00;
	logic        pcLoad, stackFaultReset, stackOverflowFlag, stackUnderflowFlag;
	logic [14:0] pcLoadValue, flashAddr;
	logic [4:0]  stackPtr;
	logic        accBusy, accDone, dataRe, dataWe, flashRe;
	logic [7:0]  accRdata, dataWdata, dataRdata;
	logic [11:0] dataAddr;
	logic [13:0] flashRdata;
	logic [11:0] lastAddr = 12'h000;
	logic [14:0] lastFlash = 15'h0000;
	int          numErrors = 0;
	int          checks = 0;
	int          cycles = 0;
	int          faultResets = 0;
	int          dataPulses = 0;
	int          flashPulses = 0;

	iam_indirect_address_mapper dut (.clock(clock), .rstn(rstn), .pushReq(pushReq), .pushAddr(pushAddr),
		.popReq(popReq), .stackFaultResetEnable(stackFaultResetEnable), .clearOverflowFlag(clearOverflowFlag),
		.clearUnderflowFlag(clearUnderflowFlag), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .stackPtr(stackPtr),
		.stackFaultReset(stackFaultReset), .stackOverflowFlag(stackOverflowFlag),
		.stackUnderflowFlag(stackUnderflowFlag), .accReq(accReq), .accWrite(accWrite), .accWdata(accWdata),
		.pointerHighByte(pointerHighByte), .pointerLowByte(pointerLowByte), .accBusy(accBusy), .accDone(accDone),
		.accRdata(accRdata), .dataAddr(dataAddr), .dataRe(dataRe), .dataWe(dataWe), .dataWdata(dataWdata),
		.dataRdata(dataRdata), .flashAddr(flashAddr), .flashRe(flashRe), .flashRdata(flashRdata));

	iam_memory_model memory (.clock(clock), .dataAddr(dataAddr), .dataRe(dataRe), .dataWe(dataWe),
		.dataWdata(dataWdata), .dataRdata(dataRdata), .flashAddr(flashAddr), .flashRe(flashRe),
		.flashRdata(flashRdata));

	// -----------------------------------------------------------
	// Clock, timeout and port watcher
	// -----------------------------------------------------------
	always #10 clock = ~clock;

	always @(posedge clock)
	begin
		cycles++;
		if (stackFaultReset === 1'b1)
			faultResets++;
		if (dataRe === 1'b1 || dataWe === 1'b1)
		begin
			dataPulses++;
			lastAddr = dataAddr;
		end
		if (flashRe === 1'b1)
		begin
			flashPulses++;
			lastFlash = flashAddr;
		end
		if (cycles >= 3000)
		begin
			numErrors++;
			end_sim();
		end
	end

	// -----------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", checks, numErrors);
		if (numErrors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			numErrors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic step;
		@(posedge clock);
		#1;
	endtask

	// The push strobe stays high across the n steps of one call and drops after its last push.
	task automatic push_run(input logic [14:0] base, input int n);
		for (int i = 0; i < n; i++)
		begin
			pushReq = 1'b1;
			pushAddr = base + 15'(i);
			step();
		end
		pushReq = 1'b0;
	endtask

	task automatic pop_one(input logic expLoad, input logic [14:0] expValue);
		popReq = 1'b1;
		step();
		popReq = 1'b0;
		check_val("pcLoad", 16'(expLoad), 16'(pcLoad));
		if (expLoad)
			check_val("pcLoadValue", 16'(expValue), 16'(pcLoadValue));
		step();
	endtask

	// The done cycle still shows busy, so a fresh request waits one edge first.
	task automatic acc(input logic wr, input logic [15:0] ptr, input logic [7:0] wd, input logic [7:0] expRd,
		input int expLat, input int expData, input int expFlash);
		int lat;
		step();
		accReq = 1'b1;
		accWrite = wr;
		accWdata = wd;
		pointerHighByte = ptr[15:8];
		pointerLowByte = ptr[7:0];
		dataPulses = 0;
		flashPulses = 0;
		step();
		accReq = 1'b0;
		check_val("accBusy", 16'h0001, 16'(accBusy));
		lat = 1;
		while (accDone !== 1'b1 && lat < 12)
		begin
			step();
			lat++;
		end
		check_val("accRdata", 16'(expRd), 16'(accRdata));
		check_val("latency", 16'(expLat), 16'(lat));
		check_val("dataPulses", 16'(expData), 16'(dataPulses));
		check_val("flashPulses", 16'(expFlash), 16'(flashPulses));
	endtask

	// -----------------------------------------------------------
	// Sequence
	// -----------------------------------------------------------
	initial
	begin
		logic [13:0] flashWord;
		flashWord = 14'h0005 ^ 14'h2c3a;
		repeat (12) @(posedge clock);
		#1;
		rstn = 1'b1;
		check_val("stackPtr", 16'h001f, 16'(stackPtr));
		push_run(15'h0100, 16);
		check_val("stackPtr", 16'h000f, 16'(stackPtr));
		push_run(15'h0200, 1);
		check_val("overflowFlag", 16'h0001, 16'(stackOverflowFlag));
		check_val("stackPtr", 16'h001f, 16'(stackPtr));
		step();
		check_val("faultResets", 16'h0001, 16'(faultResets));
		clearOverflowFlag = 1'b1;
		step();
		clearOverflowFlag = 1'b0;
		step();
		check_val("overflowFlag", 16'h0000, 16'(stackOverflowFlag));
		push_run(15'h0300, 16);
		for (int i = 15; i >= 0; i--)
			pop_one(1'b1, 15'h0300 + 15'(i));
		check_val("stackPtr", 16'h001f, 16'(stackPtr));
		pop_one(1'b0, 15'h0000);
		check_val("underflowFlag", 16'h0001, 16'(stackUnderflowFlag));
		check_val("faultResets", 16'h0002, 16'(faultResets));
		clearUnderflowFlag = 1'b1;
		step();
		clearUnderflowFlag = 1'b0;
		check_val("underflowFlag", 16'h0000, 16'(stackUnderflowFlag));
		stackFaultResetEnable = 1'b0;
		push_run(15'h0400, 17);
		check_val("stackPtr", 16'h0000, 16'(stackPtr));
		check_val("faultResets", 16'h0002, 16'(faultResets));
		pop_one(1'b1, 15'h0410);
		acc(1'b1, 16'h0123, 8'h5a, 8'h00, 3, 1, 0);
		check_val("dataAddr", 16'h0123, 16'(lastAddr));
		acc(1'b0, 16'h0123, 8'h00, 8'h5a, 3, 1, 0);
		acc(1'b1, 16'h204f, 8'h11, 8'h00, 3, 1, 0);
		check_val("dataAddr", 16'h006f, 16'(lastAddr));
		acc(1'b1, 16'h2050, 8'h22, 8'h00, 3, 1, 0);
		check_val("dataAddr", 16'h00a0, 16'(lastAddr));
		acc(1'b1, 16'h29af, 8'h33, 8'h00, 3, 1, 0);
		check_val("dataAddr", 16'h0f6f, 16'(lastAddr));
		acc(1'b0, 16'h006f, 8'h00, 8'h11, 3, 1, 0);
		acc(1'b0, 16'h2050, 8'h00, 8'h22, 3, 1, 0);
		acc(1'b1, 16'h0080, 8'h77, 8'h00, 3, 0, 0);
		check_val("memory080", 16'(8'h80 ^ 8'ha5), 16'(memory.mem[12'h080]));
		acc(1'b0, 16'h0001, 8'h00, 8'h00, 3, 0, 0);
		acc(1'b0, 16'h1500, 8'h00, 8'h00, 3, 0, 0);
		acc(1'b0, 16'h29b0, 8'h00, 8'h00, 3, 0, 0);
		acc(1'b1, 16'h7fff, 8'h44, 8'h00, 3, 0, 0);
		acc(1'b0, 16'h8005, 8'h00, flashWord[7:0], 4, 0, 1);
		check_val("flashAddr", 16'h0005, 16'(lastFlash));
		acc(1'b1, 16'h8005, 8'hff, 8'h00, 3, 0, 0);
		acc(1'b0, 16'h8005, 8'h00, flashWord[7:0], 4, 0, 1);
		end_sim();
	end
endmodule
